/* File: dct_far_end.sv */
// far-end model: neighbouring stack device driving the daisy clock and data pins
// assumes the caller raises run only while a frame is in flight
module dct_far_end (
    input  wire logic run,
    output logic      daisy_clk,
    output logic      daisy_dat
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] pat_q;

    initial
    begin
        daisy_clk = 1'b0;
        daisy_dat = 1'b0;
        pat_q     = 8'h4b;
    end

    // ****************************************
    // clock and data
    // ****************************************
    // clock stands low between frames; the odd offset keeps its edges off the core edges
    always
    begin
        wait (run);
        #0.3;
        while (run)
        begin
            #62.5 daisy_clk = 1'b1;
            daisy_dat = pat_q[7];
            pat_q     = {pat_q[6:0], pat_q[7]};
            #62.5 daisy_clk = 1'b0;
        end
        // released line: show the inverse so a stale level is never mistaken for data
        daisy_dat = ~daisy_dat;
    end
endmodule

/* File: dct_pkg.sv */
// types shared by the daisy chain timing engine
// assumes dct_regs.svh is compiled alongside
package dct_pkg;
    typedef enum logic [1:0] {
        DCT_ROLE_ALONE  = 2'b00,
        DCT_ROLE_MASTER = 2'b01,
        DCT_ROLE_MIDDLE = 2'b10,
        DCT_ROLE_TOP    = 2'b11
    } dct_role_t;

    typedef struct packed {
        dct_role_t  role;
        logic [3:0] my_pos;
        logic [3:0] top_pos;
        logic [3:0] target_pos;
        logic       broadcast;
    } dct_cfg_t;

    typedef enum logic [2:0] {
        DCT_TX_IDLE  = 3'b000,
        DCT_TX_PAD   = 3'b001,
        DCT_TX_LOAD  = 3'b010,
        DCT_TX_SHIFT = 3'b011,
        DCT_TX_TAIL  = 3'b100,
        DCT_TX_TURN  = 3'b101
    } dct_tx_state_t;
endpackage

/* File: dct_regs.svh */
// timing counts and field constants for the daisy chain timing engine
// assumes the includer works on the 250 MHz core clock
`ifndef DCT_REGS_SVH
`define DCT_REGS_SVH
`define DCT_BITS_PER_BYTE  4'h8
`define DCT_TOP_TAIL_FIX   8'h0a
`define DCT_TURN_CLOCKS    4'h8
`define DCT_FWD_EDGES      4'h8
`define DCT_POS_MASTER     4'h1
`define DCT_POS_OFFSET     8'h02
`define DCT_FIFO_DEPTH     8
`define DCT_BYTE_W         8
`define DCT_CORE_PERIOD_PS 4000
`endif

/* File: dct_timing.sv */
// daisy chain command start and response timing engine, with its response fifo
// assumes pins arrive unsynchronised and decoder strobes arrive on core_clk
// What this block does
// - top relay adds N-n-1 daisy clocks
// - middle response adds n-2 daisy clocks
// - top response: 8 per byte, +10, +N-2
// - stand-alone starts operation at command end
// - chained target starts when command reaches it
// - broadcast ends at top, each starts individually
// - non-master ports return to receive after response
// - master start follows last spi edge
// - command end grows with stack size
// - master forwards after first byte, one-clock relay
// - start scan on final falling edge
`include "dct_regs.svh"

// ****************************************
// response fifo
// ****************************************
module dct_fifo #(
    parameter int WIDTH = `DCT_BYTE_W,
    parameter int DEPTH = `DCT_FIFO_DEPTH
) (
    input  wire logic             core_clk,
    input  wire logic             clk_en,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        wp_d  = push ? wp_q + 1'b1 : wp_q;
        rp_d  = pop ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else if (clk_en)
        begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            if (push)
                mem[wp_q] <= in_data;
        end
    end
endmodule

// ****************************************
// timing engine
// ****************************************
module dct_timing (
    input  wire logic              core_clk,
    input  wire logic              clk_en,
    input  wire logic              reset,
    input  wire dct_pkg::dct_cfg_t cfg,
    input  wire logic              spi_sck,
    input  wire logic              spi_cs_n,
    input  wire logic              daisy_clk,
    input  wire logic              daisy_rx_dat,
    output logic                   daisy_tx_dat,
    output logic                   daisy_dat_oe,
    input  wire logic              cmd_is_scan,
    input  wire logic              cmd_last_bit,
    input  wire logic              resp_go,
    input  wire logic [5:0]        resp_bytes,
    input  wire logic              resp_valid,
    output logic                   resp_ready,
    input  wire logic [7:0]        resp_data,
    output logic                   start_scan,
    output logic                   fwd_active,
    output logic                   relay_dat,
    output logic                   cmd_done,
    output logic                   resp_busy,
    output logic                   rx_ready
);
    // extra daisy clocks before a response leaves this device
    function automatic logic [7:0] pad_clocks(input dct_pkg::dct_cfg_t c);
        logic [7:0] p;
        p = 8'h00;
        if (c.role == dct_pkg::DCT_ROLE_TOP && c.target_pos != c.top_pos)
            p = 8'(c.top_pos) - 8'(c.target_pos) - 8'h01;
        else if (c.role == dct_pkg::DCT_ROLE_MIDDLE)
            p = 8'(c.my_pos) - `DCT_POS_OFFSET;
        return p;
    endfunction

    // ****************************************
    // pin synchronisers and edge finders
    // ****************************************
    logic [3:0] s1_q, s2_q, s3_q;
    logic       dfall, sfall, cs_hi;
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            // idle levels: select high, clocks and data low, so no false fall after reset
            s1_q <= 4'h8;
            s2_q <= 4'h8;
            s3_q <= 4'h8;
        end
        else if (clk_en)
        begin
            s1_q <= {spi_cs_n, daisy_rx_dat, spi_sck, daisy_clk};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign dfall = s3_q[0] && !s2_q[0];
    assign sfall = s3_q[1] && !s2_q[1];
    assign cs_hi = s2_q[3];

    // ****************************************
    // command side: start scan, forwarding, command end
    // ****************************************
    logic       on_spi, targeted, cmd_edge;
    logic       start_q, start_d, fwd_q, fwd_d, relay_q, relay_d, done_q, done_d;
    logic       tail_q, tail_d;
    logic [3:0] sedge_q, sedge_d;
    logic [7:0] end_q, end_d;

    assign on_spi   = cfg.role == dct_pkg::DCT_ROLE_ALONE || cfg.role == dct_pkg::DCT_ROLE_MASTER;
    assign targeted = cfg.broadcast || cfg.target_pos == cfg.my_pos;
    assign cmd_edge = on_spi ? sfall : dfall;

    always_comb
    begin
        // started locally as soon as the last bit arrives here, not at stack end
        start_d = cmd_edge && cmd_last_bit && cmd_is_scan && targeted;
        sedge_d = sedge_q;
        fwd_d   = fwd_q;
        relay_d = relay_q;
        done_d  = 1'b0;
        tail_d  = tail_q;
        end_d   = end_q;
        if (cfg.role == dct_pkg::DCT_ROLE_MASTER)
        begin
            if (cs_hi)
            begin
                // count restarts on every deselect so a short command leaves no residue
                sedge_d = 4'h0;
                if (fwd_q)
                begin
                    fwd_d  = 1'b0;
                    tail_d = 1'b1;
                    end_d  = 8'(cfg.top_pos) - `DCT_POS_OFFSET;
                end
            end
            else if (sfall && !fwd_q)
            begin
                sedge_d = sedge_q + 4'h1;
                fwd_d   = (sedge_q + 4'h1) == `DCT_FWD_EDGES;
            end
        end
        if (tail_q && dfall)
        begin
            if (end_q == 8'h00)
            begin
                tail_d = 1'b0;
                done_d = 1'b1;
            end
            else
                end_d = end_q - 8'h01;
        end
        if (dfall)
            relay_d = s2_q[2];
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            start_q <= 1'b0;
            fwd_q   <= 1'b0;
            relay_q <= 1'b0;
            done_q  <= 1'b0;
            tail_q  <= 1'b0;
            sedge_q <= 4'h0;
            end_q   <= 8'h00;
        end
        else if (clk_en)
        begin
            start_q <= start_d;
            fwd_q   <= fwd_d;
            relay_q <= relay_d;
            done_q  <= done_d;
            tail_q  <= tail_d;
            sedge_q <= sedge_d;
            end_q   <= end_d;
        end
    end

    assign start_scan = start_q;
    assign fwd_active = fwd_q;
    assign relay_dat  = relay_q;
    assign cmd_done   = done_q;

    // ****************************************
    // response transmitter
    // ****************************************
    dct_pkg::dct_tx_state_t st_q, st_d;
    logic [7:0] cnt_q, cnt_d, sh_q, sh_d, f_data;
    logic [5:0] bcnt_q, bcnt_d;
    logic [2:0] bit_q, bit_d;
    logic       dout_q, dout_d, oe_q, oe_d, f_valid, f_pop;

    dct_fifo #(.WIDTH(`DCT_BYTE_W), .DEPTH(`DCT_FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .clk_en    (clk_en),
        .reset     (reset),
        .in_valid  (resp_valid),
        .in_ready  (resp_ready),
        .in_data   (resp_data),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    assign f_pop = st_q == dct_pkg::DCT_TX_LOAD && f_valid;

    always_comb
    begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        sh_d   = sh_q;
        bcnt_d = bcnt_q;
        bit_d  = bit_q;
        dout_d = dout_q;
        oe_d   = oe_q;
        case (st_q)
            dct_pkg::DCT_TX_IDLE:
            begin
                if (resp_go && resp_bytes != 6'h00)
                begin
                    bcnt_d = resp_bytes;
                    cnt_d  = pad_clocks(cfg);
                    oe_d   = 1'b1;
                    dout_d = 1'b0;
                    st_d   = dct_pkg::DCT_TX_PAD;
                end
            end
            dct_pkg::DCT_TX_PAD:
            begin
                if (cnt_q == 8'h00)
                    st_d = dct_pkg::DCT_TX_LOAD;
                else if (dfall)
                    cnt_d = cnt_q - 8'h01;
            end
            dct_pkg::DCT_TX_LOAD:
            begin
                // an empty fifo stalls the byte stream rather than sending junk
                if (f_valid)
                begin
                    sh_d  = f_data;
                    bit_d = 3'h0;
                    st_d  = dct_pkg::DCT_TX_SHIFT;
                end
            end
            dct_pkg::DCT_TX_SHIFT:
            begin
                if (dfall && bcnt_q == 6'h00)
                begin
                    // the last bit keeps a full daisy period before the port lets go
                    cnt_d = 8'(`DCT_TURN_CLOCKS);
                    st_d  = dct_pkg::DCT_TX_TURN;
                end
                else if (dfall)
                begin
                    dout_d = sh_q[7];
                    sh_d   = {sh_q[6:0], 1'b0};
                    bit_d  = bit_q + 3'h1;
                    if (bit_q == 3'(`DCT_BITS_PER_BYTE - 4'h1))
                    begin
                        bcnt_d = bcnt_q - 6'h01;
                        if (bcnt_q != 6'h01)
                            st_d = dct_pkg::DCT_TX_LOAD;
                        else if (cfg.role == dct_pkg::DCT_ROLE_TOP)
                        begin
                            cnt_d = `DCT_TOP_TAIL_FIX + 8'(cfg.top_pos)
                                    - `DCT_POS_OFFSET;
                            st_d  = dct_pkg::DCT_TX_TAIL;
                        end
                    end
                end
            end
            dct_pkg::DCT_TX_TAIL:
            begin
                if (cnt_q == 8'h00)
                begin
                    cnt_d = 8'(`DCT_TURN_CLOCKS);
                    st_d  = dct_pkg::DCT_TX_TURN;
                end
                else if (dfall)
                    cnt_d = cnt_q - 8'h01;
            end
            dct_pkg::DCT_TX_TURN:
            begin
                // port released at once; the window covers the host's wait
                oe_d   = 1'b0;
                dout_d = 1'b0;
                if (cnt_q == 8'h00)
                    st_d = dct_pkg::DCT_TX_IDLE;
                else if (dfall)
                    cnt_d = cnt_q - 8'h01;
            end
            default:
            begin
                st_d = dct_pkg::DCT_TX_IDLE;
                oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_q   <= dct_pkg::DCT_TX_IDLE;
            cnt_q  <= 8'h00;
            sh_q   <= 8'h00;
            bcnt_q <= 6'h00;
            bit_q  <= 3'h0;
            dout_q <= 1'b0;
            oe_q   <= 1'b0;
        end
        else if (clk_en)
        begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            sh_q   <= sh_d;
            bcnt_q <= bcnt_d;
            bit_q  <= bit_d;
            dout_q <= dout_d;
            oe_q   <= oe_d;
        end
    end

    assign daisy_tx_dat = dout_q;
    assign daisy_dat_oe = oe_q;
    assign resp_busy    = st_q != dct_pkg::DCT_TX_IDLE;
    assign rx_ready     = st_q == dct_pkg::DCT_TX_IDLE;

    // ****************************************
    // checks
    // ****************************************
    property p_start_edge;
        @(posedge core_clk) disable iff (reset)
        clk_en && cmd_edge && cmd_last_bit && cmd_is_scan && targeted |=> start_scan;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("start scan missed");
    property p_start_cause;
        @(posedge core_clk) disable iff (reset)
        $rose(start_scan) |-> $past(cmd_last_bit) && $past(targeted);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("spurious start");
    property p_pad_load;
        @(posedge core_clk) disable iff (reset)
        clk_en && st_q == dct_pkg::DCT_TX_IDLE && resp_go && resp_bytes != 6'h00
        |=> cnt_q == pad_clocks(cfg);
    endproperty
    a_pad_load: assert property (p_pad_load) else $error("pad count wrong");
    property p_mid_pad;
        @(posedge core_clk) disable iff (reset)
        cfg.role == dct_pkg::DCT_ROLE_MIDDLE |-> pad_clocks(cfg) == 8'(cfg.my_pos) - 8'h02;
    endproperty
    a_mid_pad: assert property (p_mid_pad) else $error("middle pad wrong");
    property p_top_tail;
        @(posedge core_clk) disable iff (reset)
        $changed(st_q) && st_q == dct_pkg::DCT_TX_TAIL
        |-> cnt_q == 8'h08 + 8'(cfg.top_pos);
    endproperty
    a_top_tail: assert property (p_top_tail) else $error("top tail wrong");
    property p_turn_off;
        @(posedge core_clk) disable iff (reset)
        st_q == dct_pkg::DCT_TX_TURN ##1 st_q == dct_pkg::DCT_TX_TURN |-> !daisy_dat_oe;
    endproperty
    a_turn_off: assert property (p_turn_off) else $error("port still driven");
    property p_fwd_edges;
        @(posedge core_clk) disable iff (reset)
        $rose(fwd_active) |-> $past(sedge_q) == 4'h7 && cfg.role == dct_pkg::DCT_ROLE_MASTER;
    endproperty
    a_fwd_edges: assert property (p_fwd_edges) else $error("forward too early");
    property p_done_after;
        @(posedge core_clk) disable iff (reset)
        cmd_done |-> $past(tail_q) && $past(end_q) == 8'h00 && $past(dfall);
    endproperty
    a_done_after: assert property (p_done_after) else $error("command end early");
    property p_turn_daisy;
        @(posedge core_clk) disable iff (reset)
        st_q == dct_pkg::DCT_TX_TURN && clk_en && !dfall && cnt_q != 8'h00 |=> $stable(cnt_q);
    endproperty
    a_turn_daisy: assert property (p_turn_daisy) else $error("turnaround not daisy");
endmodule

/* File: tb_dct_timing.sv */
// self-checking bench for the daisy chain timing engine
// assumes dct_pkg, dct_timing.sv and dct_far_end.sv are compiled first
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end

module tb_dct_timing;
    timeunit 1ns;
    timeprecision 100ps;

    logic              core_clk     = 1'b0;
    logic              clk_en       = 1'b1;
    logic              reset        = 1'b1;
    dct_pkg::dct_cfg_t cfg          = '0;
    logic              spi_sck      = 1'b0;
    logic              spi_cs_n     = 1'b1;
    logic              daisy_run    = 1'b0;
    logic              daisy_clk;
    logic              daisy_dat_i;
    logic              daisy_dat_o;
    logic              daisy_dat_oe;
    logic              cmd_is_scan  = 1'b0;
    logic              cmd_last_bit = 1'b0;
    logic              resp_go      = 1'b0;
    logic [5:0]        resp_bytes   = 6'h00;
    logic              resp_valid   = 1'b0;
    logic              resp_ready;
    logic [7:0]        resp_data    = 8'h00;
    logic              start_scan;
    logic              fwd_active;
    logic              relay_dat;
    logic              cmd_done;
    logic              resp_busy;
    logic              rx_ready;
    int                bad_count    = 0;
    int                num_checks   = 0;
    int                cyc          = 0;
    int                scan_cnt     = 0;
    int                done_cnt     = 0;

    dct_timing DUT (
        .core_clk(core_clk), .clk_en(clk_en), .reset(reset), .cfg(cfg),
        .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .daisy_clk(daisy_clk),
        .daisy_rx_dat(daisy_dat_i), .daisy_tx_dat(daisy_dat_o), .daisy_dat_oe(daisy_dat_oe),
        .cmd_is_scan(cmd_is_scan), .cmd_last_bit(cmd_last_bit), .resp_go(resp_go),
        .resp_bytes(resp_bytes), .resp_valid(resp_valid), .resp_ready(resp_ready),
        .resp_data(resp_data), .start_scan(start_scan), .fwd_active(fwd_active),
        .relay_dat(relay_dat), .cmd_done(cmd_done), .resp_busy(resp_busy),
        .rx_ready(rx_ready)
    );

    dct_far_end far_end (
        .run      (daisy_run),
        .daisy_clk(daisy_clk),
        .daisy_dat(daisy_dat_i)
    );

    always #2 core_clk = ~core_clk;

    // ****************************************
    // monitors, timeout and verdict
    // ****************************************
    always @(posedge core_clk)
    begin
        cyc++;
        if (start_scan === 1'b1)
            scan_cnt++;
        if (cmd_done === 1'b1)
            done_cnt++;
        if (cyc == 40000)
        begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ****************************************
    // shared drivers
    // ****************************************
    task automatic set_cfg(input dct_pkg::dct_role_t r, input logic [3:0] m, t, g,
                           input logic b);
        @(posedge core_clk);
        #1;
        cfg = '{role: r, my_pos: m, top_pos: t, target_pos: g, broadcast: b};
    endtask

    task automatic spi_fall();
        spi_sck = 1'b1;
        #250;
        spi_sck = 1'b0;
        #250;
    endtask

    task automatic push_byte(input logic [7:0] b);
        resp_data  = b;
        resp_valid = 1'b1;
        do
            @(posedge core_clk);
        while (resp_ready !== 1'b1);
        #1;
        resp_valid = 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    // counts daisy falls with the port driven and in turnaround; samples the data at each driven fall
    task automatic run_resp(input dct_pkg::dct_role_t r, input logic [3:0] m, t, g,
                            input int push, input logic [7:0] b, input logic [5:0] nb,
                            input int pad, tail);
        logic smp [0:127];
        int   k;
        int   turn;
        set_cfg(r, m, t, g, 1'b0);
        repeat (push) push_byte(b);
        resp_bytes = nb;
        resp_go    = 1'b1;
        @(posedge core_clk);
        #1;
        resp_go = 1'b0;
        #20;
        `CHK(daisy_dat_oe, 1'b1)
        k    = 0;
        turn = 0;
        daisy_run = 1'b1;
        while (rx_ready !== 1'b1 && k + turn < 120)
        begin
            @(negedge daisy_clk);
            if (daisy_dat_oe === 1'b1)
            begin
                smp[k] = daisy_dat_o;
                k++;
            end
            else if (resp_busy === 1'b1)
                turn++;
            #40;
        end
        daisy_run = 1'b0;
        `CHK(k, pad + 8 * nb + tail)
        `CHK(smp[pad], 1'b0)
        for (int i = 0; i < 7; i++)
            `CHK(smp[pad + 1 + i], b[7 - i])
        if (tail > 0)
            `CHK(smp[pad + 8 * nb], b[0])
        `CHK(turn, 8)
        `CHK(resp_ready, 1'b1)
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        `CHK(daisy_dat_oe, 1'b0)
        `CHK(daisy_dat_o, 1'b0)
        `CHK(rx_ready, 1'b1)
        `CHK(resp_ready, 1'b1)
        `CHK(fwd_active, 1'b0)
    endtask

    // targeted and untargeted cases on both clock sources, non-scan on the spi clock, broadcast on the daisy clock
    task automatic t_scan();
        dct_pkg::dct_role_t rl [7] = '{dct_pkg::DCT_ROLE_ALONE, dct_pkg::DCT_ROLE_ALONE,
            dct_pkg::DCT_ROLE_ALONE, dct_pkg::DCT_ROLE_MASTER, dct_pkg::DCT_ROLE_MIDDLE,
            dct_pkg::DCT_ROLE_MIDDLE, dct_pkg::DCT_ROLE_TOP};
        int   my [7] = '{1, 1, 1, 1, 4, 4, 6};
        int   tg [7] = '{1, 2, 1, 1, 4, 7, 3};
        logic [6:0] bc = 7'h20;
        logic [6:0] sc = 7'h7b;
        logic [6:0] ex = 7'h39;
        int   n0;
        for (int i = 0; i < 7; i++)
        begin
            set_cfg(rl[i], 4'(my[i]), 4'h6, 4'(tg[i]), bc[i]);
            cmd_is_scan  = sc[i];
            cmd_last_bit = 1'b1;
            n0 = scan_cnt;
            if (i < 4)
            begin
                spi_cs_n = 1'b0;
                spi_fall();
                spi_cs_n = 1'b1;
            end
            else
            begin
                daisy_run = 1'b1;
                @(posedge daisy_clk);
                daisy_run = 1'b0;
                @(negedge daisy_clk);
                #250;
            end
            @(posedge core_clk);
            #1;
            cmd_last_bit = 1'b0;
            `CHK(scan_cnt - n0, int'(ex[i]))
        end
    endtask

    task automatic t_forward();
        int   d0;
        int   at;
        logic d;
        set_cfg(dct_pkg::DCT_ROLE_MASTER, 4'h1, 4'h5, 4'h2, 1'b0);
        cmd_is_scan = 1'b0;
        // host idles just over nine daisy periods, past the eight-period turnaround
        #1126;
        spi_cs_n = 1'b0;
        repeat (7) spi_fall();
        `CHK(fwd_active, 1'b0)
        spi_fall();
        `CHK(fwd_active, 1'b1)
        spi_cs_n = 1'b1;
        #40;
        `CHK(fwd_active, 1'b0)
        d0 = done_cnt;
        at = 0;
        daisy_run = 1'b1;
        for (int i = 1; i <= 6; i++)
        begin
            @(negedge daisy_clk);
            d = daisy_dat_i;
            #40;
            if (done_cnt != d0 && at == 0)
                at = i;
            `CHK(relay_dat, d)
            if (i == 5)
                daisy_run = 1'b0;
        end
        `CHK(at, 4)
        `CHK(done_cnt - d0, 1)
    endtask

    task automatic t_resp();
        run_resp(dct_pkg::DCT_ROLE_MIDDLE, 4'h5, 4'h6, 4'h5, 1, 8'ha5, 6'h01, 3, 1);
        run_resp(dct_pkg::DCT_ROLE_TOP, 4'h6, 4'h6, 4'h3, 1, 8'h96, 6'h01, 2, 14);
        run_resp(dct_pkg::DCT_ROLE_TOP, 4'h6, 4'h6, 4'h6, 2, 8'hc3, 6'h02, 0, 14);
    endtask

    // fill the buffer with the transmitter stalled, see it refuse, then drain it
    task automatic t_fifo();
        int n;
        set_cfg(dct_pkg::DCT_ROLE_ALONE, 4'h1, 4'h1, 4'h1, 1'b0);
        // with the clock enable low the buffer must not take the offered byte
        clk_en     = 1'b0;
        resp_data  = 8'h5a;
        resp_valid = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        resp_valid = 1'b0;
        clk_en     = 1'b1;
        @(posedge core_clk);
        #1;
        n = 0;
        while (resp_ready === 1'b1 && n < 12)
        begin
            push_byte(8'h5a);
            n++;
        end
        `CHK(n, 8)
        resp_valid = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(resp_ready, 1'b0)
        resp_valid = 1'b0;
        run_resp(dct_pkg::DCT_ROLE_ALONE, 4'h1, 4'h1, 4'h1, 0, 8'h5a, 6'h08, 0, 1);
    endtask

    initial
    begin
        repeat (10) @(posedge core_clk);
        #1;
        reset = 1'b0;
        repeat (4) @(posedge core_clk);
        t_reset();
        t_scan();
        t_forward();
        t_resp();
        t_fifo();
        test_done();
    end
endmodule
